/* File: design/dpal_cfg.svh */
`ifndef DPAL_CFG_SVH
`define DPAL_CFG_SVH
// core clock period and post-reset key window
`define DPAL_CLK_NS 8
`define DPAL_KEYWIN_NS 8000
// longest time, rounds down
`define DPAL_KEYWIN_CYC (`DPAL_KEYWIN_NS / `DPAL_CLK_NS)
// acquisition pattern, shared with the host side; value is arbitrary
`define DPAL_ACQ_LEN 16
`define DPAL_ACQ_KEY 16'hb5e3
// lock pattern of the write-once latch; value is arbitrary
`define DPAL_LOCK_KEY 32'h6a3c_d21e
`define DPAL_LOCK_MIN 28
`define DPAL_N_BP 8
`define DPAL_TRACE_DEPTH 1000
`define DPAL_FIFO_DEPTH 32
`define DPAL_BAUD_DIV 16
`define DPAL_HDR_BYTES 5
`endif

/* File: design/dpal_fifo.sv */
`timescale 1ns/1ps
module dpal_fifo import dpal_pkg::*; #(
  parameter int WIDTH = 37,
  parameter int DEPTH = 32
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH]; // flop storage
  logic [AW:0] wr_ff; // extra bit tells full from empty
  logic [AW:0] rd_ff;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (wr_ff - rd_ff) != (AW+1)'(DEPTH);
  assign out_valid = wr_ff != rd_ff;
  assign out_data = mem_ff[rd_ff[AW-1:0]];
  // pointers
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wr_ff <= '0;
      rd_ff <= '0;
    end else begin
      if (push) wr_ff <= wr_ff + 1'b1;
      if (pop) rd_ff <= rd_ff + 1'b1;
    end
  end
  // storage has no reset, only valid slots are read
  always_ff @(posedge clock) begin
    if (push) mem_ff[wr_ff[AW-1:0]] <= in_data;
  end
endmodule

/* File: design/dpal_pkg.sv */
package dpal_pkg;
  // which pin pair carries the two-wire port
  typedef enum logic [1:0] {DPAL_PAIR_NONE, DPAL_PAIR_JTAG,
                            DPAL_PAIR_USB} dpal_pair_e;
  // one viewer word: channel and payload
  typedef struct packed {
    logic [4:0] chan;
    logic [31:0] data;
  } dpal_swv_s;
  // one trace record
  typedef struct packed {
    logic [15:0] pc;
    logic [7:0] acc;
    logic [7:0] sreg;
  } dpal_trace_s;
  // cpu data access seen by the memory breakpoint
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] data;
    logic rd;
    logic wr;
  } dpal_mem_s;
endpackage

/* File: design/dpal_swv_tx.sv */
`timescale 1ns/1ps
`include "dpal_cfg.svh"
module dpal_swv_tx import dpal_pkg::*; #(
  parameter int BAUD_DIV = `DPAL_BAUD_DIV
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic manch,
  input wire logic in_valid,
  output logic in_ready,
  input wire dpal_swv_s in_data,
  output logic tx_o
);
  logic busy_ff;
  logic [39:0] buf_ff; // channel byte then payload, low byte first
  logic [2:0] byte_ff;
  logic [3:0] bit_ff;
  logic half_ff;
  logic [15:0] div_ff;
  logic tx_ff;
  wire tick = div_ff == 16'h0000;
  wire [3:0] last_bit = manch ? 4'h7 : 4'h9;
  wire bit_end = tick && (!manch || half_ff);
  wire byte_end = bit_end && bit_ff == last_bit;
  // uart: start, eight data, stop; manchester: data then inverse
  wire [3:0] didx = manch ? bit_ff : bit_ff - 4'h1;
  wire dbit = buf_ff[didx[2:0]];
  wire uart_sym = (bit_ff == 4'h0) ? 1'b0 :
                  (bit_ff == 4'h9) ? 1'b1 : dbit;
  wire sym = manch ? (dbit ^ half_ff) : uart_sym;
  assign in_ready = !busy_ff;
  assign tx_o = tx_ff;
  // symbol engine
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      busy_ff <= 1'b0;
      buf_ff <= '0;
      byte_ff <= '0;
      bit_ff <= '0;
      half_ff <= 1'b0;
      div_ff <= '0;
      tx_ff <= 1'b1;
    end else if (!busy_ff) begin
      tx_ff <= 1'b1; // line idles high
      if (in_valid) begin
        busy_ff <= 1'b1;
        buf_ff <= {in_data.data, 3'b000, in_data.chan};
        byte_ff <= '0;
        bit_ff <= '0;
        half_ff <= 1'b0;
        div_ff <= '0;
      end
    end else begin
      div_ff <= tick ? 16'(BAUD_DIV - 1) : div_ff - 16'h0001;
      if (tick) tx_ff <= sym;
      if (tick && manch) half_ff <= !half_ff;
      if (bit_end) bit_ff <= bit_ff + 4'h1;
      if (byte_end) begin
        bit_ff <= '0;
        buf_ff <= {8'h00, buf_ff[39:8]};
        byte_ff <= byte_ff + 3'h1;
        if (byte_ff == 3'(`DPAL_HDR_BYTES - 1)) busy_ff <= 1'b0;
      end
    end
  end
endmodule

/* File: design/dpal_top.sv */
`timescale 1ns/1ps
`include "dpal_cfg.svh"
// Summary of operation
// - debug circuits off at reset, firmware enables
// - once refused, only full erase or this block's reset restores
// - scan port on by default, strap disables
// - two-wire port on exactly one pin pair
// - key pattern must arrive inside reset window
// - two-wire reacquire allowed only inside key window, reopens scan
// - eight address comparators, halt and step
// - one address-and-data memory breakpoint
// - ordered two-hit breakpoint sequence, non-recursive
// - debug logic independent of cpu reset, sleep
// - trace pc, acc, register; 1000/2000 deep
// - trace starts on trigger, optional pc window
// - full trace buffer wraps or halts cpu
// - viewer drives scan data-out, two-wire only
// - 32 channels, uart n81 or manchester
// - protection cleared by full erase; block gating
// - latch true when 28 of 32 match
// - latch true blocks debug and latch writes
// - latch sampled only after reset release
// - latch key write needs no flash protection
module dpal_top import dpal_pkg::*; #(
  parameter int N_BP = `DPAL_N_BP,
  parameter int TRACE_DEPTH = `DPAL_TRACE_DEPTH,
  parameter int FIFO_DEPTH = `DPAL_FIFO_DEPTH
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic jtag_dis_cfg,
  input wire logic tck_i,
  input wire logic tms_i,
  output logic tms_o,
  output logic tms_oe,
  output logic tdo_o,
  output logic tdo_oe,
  input wire logic usb_dp_i,
  input wire logic usb_dm_i,
  output logic usb_dm_o,
  output logic usb_dm_oe,
  input wire logic jtag_tdo_core,
  input wire logic jtag_tdo_en,
  input wire logic swd_dout,
  input wire logic swd_doe,
  output logic swd_din,
  output logic swd_clk_rise,
  input wire logic swd_dis,
  input wire logic swd_jtag_en,
  input wire logic fw_jtag_dis,
  output logic jtag_active,
  output dpal_pair_e swd_pair,
  output logic key_window,
  input wire logic fw_doc_en,
  input wire logic fw_doc_dis,
  output logic on_chip_debug_circuits,
  input wire logic full_erase,
  input wire logic prot_set,
  output logic prot_any,
  input wire logic blk_op_req,
  input wire logic blk_sec_ok,
  output logic blk_op_ok,
  input wire logic wol_wr,
  input wire logic [31:0] wol_wdata,
  input wire logic wol_commit,
  input wire logic [31:0] nonvolatile_latch_cell,
  output logic nvl_prog,
  output logic [31:0] nvl_prog_data,
  output logic write_once_security_latch,
  input wire logic dbg_halt_req,
  input wire logic dbg_resume,
  input wire logic dbg_step,
  output logic cpu_halt,
  input wire logic cpu_retire,
  input wire dpal_trace_s cpu_state,
  input wire dpal_mem_s cpu_mem,
  input wire logic [N_BP*16-1:0] bp_addr,
  input wire logic [N_BP-1:0] bp_en,
  input wire dpal_mem_s mbp_cfg,
  input wire logic seq_en,
  input wire logic [2:0] seq_first,
  input wire logic [2:0] seq_second,
  input wire logic trc_en,
  input wire logic trc_all,
  input wire logic trc_cont,
  input wire logic [15:0] trc_trig,
  input wire logic trc_win_en,
  input wire logic [15:0] trc_win_lo,
  input wire logic [15:0] trc_win_hi,
  input wire logic [10:0] trc_rd_idx,
  output dpal_trace_s trc_rd_data,
  output logic [10:0] trc_count,
  output logic trc_wrapped,
  input wire logic swv_en,
  input wire logic swv_manch,
  input wire logic swv_valid,
  output logic swv_ready,
  input wire dpal_swv_s swv_word
);
  localparam int WINW = 10;
  localparam int KW = `DPAL_ACQ_LEN;
  localparam int TW = $clog2(TRACE_DEPTH);

  // ---- pin synchronisers: three stages, change once 2 and 3 agree
  wire [3:0] ext_w = {usb_dm_i, usb_dp_i, tms_i, tck_i};
  logic [3:0] s1_ff, s2_ff, s3_ff, lvl_ff;
  logic [3:0] nxt_lvl;
  for (genvar g = 0; g < 4; g++) begin : g_sync
    assign nxt_lvl[g] = (s2_ff[g] == s3_ff[g]) ? s3_ff[g] : lvl_ff[g];
  end
  wire [3:0] rise_w = nxt_lvl & ~lvl_ff;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      lvl_ff <= '0;
    end else begin
      s1_ff <= ext_w;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      lvl_ff <= nxt_lvl;
    end
  end

  // ---- latch sampling, one cycle after release
  logic samp_ff, locked_ff;
  logic [5:0] match_cnt;
  wire [31:0] eq_w = ~(nonvolatile_latch_cell ^ `DPAL_LOCK_KEY);
  always_comb begin
    match_cnt = '0;
    for (int i = 0; i < 32; i++) match_cnt = match_cnt + 6'(eq_w[i]);
  end
  // super-majority, so a few dead cells never drop the lock
  wire lock_match = match_cnt >= 6'(`DPAL_LOCK_MIN);
  // locked until sampled: no access window before the check
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      samp_ff <= 1'b0;
      locked_ff <= 1'b1;
    end else if (!samp_ff) begin
      samp_ff <= 1'b1;
      locked_ff <= lock_match;
    end
  end
  assign write_once_security_latch = locked_ff;

  // ---- key window and pair acquisition
  logic [WINW-1:0] win_ff;
  logic [KW-1:0] jsh_ff, ush_ff;
  dpal_pair_e pair_ff;
  assign key_window = win_ff < WINW'(`DPAL_KEYWIN_CYC);
  wire j_hit = jsh_ff == `DPAL_ACQ_KEY;
  wire u_hit = ush_ff == `DPAL_ACQ_KEY;
  // reacquire ignores any earlier disable, only the lock or a closed key window refuses
  wire acq_ok = key_window && samp_ff && !locked_ff;
  // a taken key is spent, so a dropped pair needs a fresh key
  wire take = pair_ff == DPAL_PAIR_NONE && acq_ok && (j_hit || u_hit);
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      win_ff <= '0;
      jsh_ff <= '0;
      ush_ff <= '0;
      pair_ff <= DPAL_PAIR_NONE;
    end else begin
      if (key_window) win_ff <= win_ff + 1'b1;
      if (take) begin
        jsh_ff <= '0;
        ush_ff <= '0;
      end else begin
        if (rise_w[0]) jsh_ff <= {jsh_ff[KW-2:0], lvl_ff[1]};
        if (rise_w[2]) ush_ff <= {ush_ff[KW-2:0], lvl_ff[3]};
      end
      // first pair to match owns the port
      if (pair_ff == DPAL_PAIR_NONE && acq_ok) begin
        if (j_hit) pair_ff <= DPAL_PAIR_JTAG;
        else if (u_hit) pair_ff <= DPAL_PAIR_USB;
      end else if (swd_dis || locked_ff) begin
        pair_ff <= DPAL_PAIR_NONE;
      end
    end
  end
  assign swd_pair = pair_ff;
  wire on_j = pair_ff == DPAL_PAIR_JTAG;
  wire on_u = pair_ff == DPAL_PAIR_USB;
  assign swd_din = on_u ? lvl_ff[3] : lvl_ff[1];
  assign swd_clk_rise = on_u ? rise_w[2] : (on_j && rise_w[0]);
  assign tms_o = swd_dout;
  assign tms_oe = on_j && swd_doe;
  assign usb_dm_o = swd_dout;
  assign usb_dm_oe = on_u && swd_doe;

  // ---- scan port enable
  logic jtag_en_ff;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) jtag_en_ff <= 1'b1;
    else if (swd_jtag_en && pair_ff != DPAL_PAIR_NONE)
      jtag_en_ff <= 1'b1;
    else if (fw_jtag_dis || (!samp_ff && jtag_dis_cfg))
      jtag_en_ff <= 1'b0;
  end
  // scan pins serve as gpio when this is low
  assign jtag_active = jtag_en_ff && !locked_ff && !on_j;

  // ---- viewer: fifo then serializer onto data-out
  dpal_swv_s vq_data;
  logic vq_valid, vq_ready, swv_tx;
  dpal_fifo #(.WIDTH($bits(dpal_swv_s)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock(clock), .arst_n(arst_n),
    .in_valid(swv_valid), .in_ready(swv_ready), .in_data(swv_word),
    .out_valid(vq_valid), .out_ready(vq_ready), .out_data(vq_data));
  // drains only while the viewer may drive, so the fifo backs up
  wire swv_live = swv_en && pair_ff != DPAL_PAIR_NONE && !jtag_active;
  logic tx_ready;
  assign vq_ready = tx_ready && swv_live;
  dpal_swv_tx u_tx (
    .clock(clock), .arst_n(arst_n), .manch(swv_manch),
    .in_valid(vq_valid && swv_live), .in_ready(tx_ready),
    .in_data(vq_data), .tx_o(swv_tx));
  logic tdo_ff, tdo_oe_ff;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      tdo_ff <= 1'b1;
      tdo_oe_ff <= 1'b0;
    end else begin
      tdo_ff <= jtag_active ? jtag_tdo_core : swv_tx;
      tdo_oe_ff <= (jtag_active && jtag_tdo_en) || swv_live;
    end
  end
  assign tdo_o = tdo_ff;
  assign tdo_oe = tdo_oe_ff;

  // ---- debug enable and flash protection
  logic doc_en_ff, doc_allow_ff, prot_ff;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      doc_en_ff <= 1'b0;
      doc_allow_ff <= 1'b1;
      prot_ff <= 1'b0;
    end else begin
      if (full_erase) doc_allow_ff <= 1'b1;
      else if (fw_doc_dis) doc_allow_ff <= 1'b0;
      if (fw_doc_en && doc_allow_ff && !locked_ff)
        doc_en_ff <= 1'b1;
      else if (fw_doc_dis || full_erase) doc_en_ff <= 1'b0;
      if (prot_set) prot_ff <= 1'b1; // set wins over erase
      else if (full_erase) prot_ff <= 1'b0;
    end
  end
  assign on_chip_debug_circuits = doc_en_ff;
  assign prot_any = prot_ff;
  assign blk_op_ok = blk_op_req && blk_sec_ok && !locked_ff;
  // debug runs off this block's own reset, not the cpu's
  wire dbg_on = doc_en_ff && !locked_ff;

  // ---- write-once latch staging
  logic [31:0] wol_vol_ff;
  logic prog_ff;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wol_vol_ff <= '0;
      prog_ff <= 1'b0;
    end else begin
      if (wol_wr && !prot_ff && !locked_ff)
        wol_vol_ff <= wol_wdata;
      prog_ff <= wol_commit && !locked_ff;
    end
  end
  assign nvl_prog = prog_ff;
  assign nvl_prog_data = wol_vol_ff;

  // ---- breakpoints
  logic [N_BP-1:0] bp_hit;
  for (genvar b = 0; b < N_BP; b++) begin : g_bp
    assign bp_hit[b] = bp_en[b] && cpu_retire &&
                       cpu_state.pc == bp_addr[b*16 +: 16];
  end
  wire mbp_hit = (mbp_cfg.rd && cpu_mem.rd || mbp_cfg.wr && cpu_mem.wr)
                 && cpu_mem.addr == mbp_cfg.addr
                 && cpu_mem.data == mbp_cfg.data;
  logic seq_arm_ff;
  wire seq_hit = seq_en && seq_arm_ff && bp_hit[seq_second];
  wire bp_halt = dbg_on && ((seq_en ? 1'b0 : |bp_hit) || mbp_hit
                            || seq_hit);
  // one pass only: the second hit disarms, no nesting
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) seq_arm_ff <= 1'b0;
    else if (!seq_en || seq_hit) seq_arm_ff <= 1'b0;
    else if (bp_hit[seq_first]) seq_arm_ff <= 1'b1;
  end

  // ---- trace capture
  logic [15:0] bank_a [TRACE_DEPTH];
  logic [15:0] bank_b [TRACE_DEPTH];
  logic [10:0] idx_ff;
  logic run_ff, stop_ff, wrap_ff;
  wire [10:0] cap = trc_all ? 11'(TRACE_DEPTH) : 11'(2*TRACE_DEPTH);
  wire in_win = cpu_state.pc >= trc_win_lo && cpu_state.pc <= trc_win_hi;
  wire trig = trc_en && dbg_on && cpu_retire && cpu_state.pc == trc_trig;
  wire cap_w = (run_ff || trig) && !stop_ff && cpu_retire && trc_en &&
               (!trc_win_en || in_win);
  wire last_w = idx_ff == cap - 11'h001;
  wire trc_full_halt = cap_w && last_w && !trc_cont;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      idx_ff <= '0;
      run_ff <= 1'b0;
      stop_ff <= 1'b0;
      wrap_ff <= 1'b0;
    end else if (!trc_en) begin
      idx_ff <= '0;
      run_ff <= 1'b0;
      stop_ff <= 1'b0;
      wrap_ff <= 1'b0;
    end else begin
      if (trig) run_ff <= 1'b1;
      if (cap_w && last_w) begin
        idx_ff <= '0;
        wrap_ff <= trc_cont;
        stop_ff <= !trc_cont;
      end else if (cap_w) begin
        idx_ff <= idx_ff + 11'h001;
      end
    end
  end
  // pc-only mode packs two records per row
  wire [TW-1:0] row = trc_all ? idx_ff[TW-1:0] : idx_ff[TW:1];
  wire wa = cap_w && (trc_all || !idx_ff[0]);
  wire wb = cap_w && (trc_all || idx_ff[0]);
  wire [15:0] b_dat = trc_all ? {cpu_state.acc, cpu_state.sreg}
                              : cpu_state.pc;
  always_ff @(posedge clock) begin
    if (wa) bank_a[row] <= cpu_state.pc;
    if (wb) bank_b[row] <= b_dat;
  end
  wire [TW-1:0] rrow = trc_all ? trc_rd_idx[TW-1:0] : trc_rd_idx[TW:1];
  dpal_trace_s rd_ff;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) rd_ff <= '0;
    else if (trc_all) rd_ff <= {bank_a[rrow], bank_b[rrow]};
    else rd_ff <= {trc_rd_idx[0] ? bank_b[rrow] : bank_a[rrow], 16'h0000};
  end
  assign trc_rd_data = rd_ff;
  assign trc_count = wrap_ff ? cap : idx_ff;
  assign trc_wrapped = wrap_ff;

  // ---- cpu halt and single step
  logic halt_ff, step_ff;
  wire halt_set = (dbg_on && dbg_halt_req) || bp_halt ||
                  (dbg_on && trc_full_halt) ||
                  (step_ff && cpu_retire);
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      halt_ff <= 1'b0;
      step_ff <= 1'b0;
    end else begin
      if (halt_set) halt_ff <= 1'b1;
      else if (dbg_resume || (dbg_step && halt_ff)) halt_ff <= 1'b0;
      if (dbg_step && halt_ff && dbg_on) step_ff <= 1'b1;
      else if (cpu_retire) step_ff <= 1'b0;
    end
  end
  assign cpu_halt = halt_ff;

  // ---- checks
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  sequence last_capture;
    cap_w && last_w && !trc_cont && dbg_on;
  endsequence
  sequence halted_stop;
    halt_ff && stop_ff;
  endsequence
  doc_enable_a: assert property ($rose(doc_en_ff) |->
    $past(fw_doc_en)) else $error("debug on without firmware enable");
  doc_refuse_a: assert property (fw_doc_en && !doc_allow_ff &&
    !doc_en_ff |=> !doc_en_ff) else $error("refused enable took effect");
  acq_window_a: assert property ($past(pair_ff) == DPAL_PAIR_NONE &&
    pair_ff != DPAL_PAIR_NONE |-> $past(key_window, 1))
    else $error("pair acquired outside key window");
  lock_major_a: assert property ($rose(samp_ff) |->
    locked_ff == $past(match_cnt >= 6'd28))
    else $error("latch majority wrong");
  lock_hold_a: assert property (samp_ff |=> $stable(locked_ff))
    else $error("latch resampled after reset");
  lock_block_a: assert property (samp_ff && locked_ff |=>
    !jtag_active && pair_ff == DPAL_PAIR_NONE && !nvl_prog)
    else $error("access while locked");
  wol_guard_a: assert property (wol_wr && prot_ff |=>
    $stable(wol_vol_ff)) else $error("key written under protection");
  bp_halt_a: assert property (dbg_on && mbp_hit |=> halt_ff)
    else $error("memory breakpoint missed");
  trc_full_a: assert property (last_capture |=> halted_stop)
    else $error("full trace did not halt");
  swv_pin_a: assert property (swv_live && !jtag_active |=>
    tdo_oe && tdo_o == $past(swv_tx)) else $error("viewer not on pin");
endmodule

/* File: verif/dpal_host.sv */
`timescale 1ns/1ps
// probe model: shifts the acquisition key onto a clock/data pin pair
module dpal_host #(
  parameter int HALF_NS = 80
) (
  input wire logic go,
  input wire logic [15:0] key,
  output logic sclk,
  output logic sdat,
  output logic busy
);
  // clock parked low between frames
  initial begin
    sclk = 1'b0;
    sdat = 1'b0;
    busy = 1'b0;
  end
  // one frame per go edge, msb first
  always @(posedge go) begin
    busy = 1'b1;
    for (int i = 15; i >= 0; i--) begin
      sdat = key[i];
      #HALF_NS sclk = 1'b1;
      #HALF_NS sclk = 1'b0;
    end
    // released line must not keep showing the last bit
    sdat = ~key[0];
    busy = 1'b0;
  end
endmodule

/* File: verif/tb_dpal_top.sv */
`timescale 1ns/1ps
`include "dpal_cfg.svh"
module tb_dpal_top import dpal_pkg::*;;
  // design inputs, and the outputs nvl_prog_data, trc_count and trc_rd_data
  logic clock, arst_n, jtag_dis_cfg, jtag_tdo_core, jtag_tdo_en, swd_dout;
  logic swd_doe, swd_dis, swd_jtag_en, fw_jtag_dis, fw_doc_en, fw_doc_dis;
  logic full_erase, prot_set, blk_op_req, blk_sec_ok, wol_wr, wol_commit;
  logic dbg_halt_req, dbg_resume, dbg_step, cpu_retire, seq_en, trc_en;
  logic trc_all, trc_cont, trc_win_en, swv_en, swv_manch, swv_valid;
  logic [31:0] wol_wdata, nonvolatile_latch_cell, nvl_prog_data;
  logic [127:0] bp_addr;
  logic [7:0] bp_en;
  logic [2:0] seq_first, seq_second;
  logic [15:0] trc_trig, trc_win_lo, trc_win_hi, host_key;
  logic [10:0] trc_rd_idx, trc_count;
  dpal_trace_s cpu_state, trc_rd_data;
  dpal_mem_s cpu_mem, mbp_cfg;
  dpal_swv_s swv_word;
  // design outputs
  logic tms_o, tms_oe, tdo_o, tdo_oe, usb_dm_o, usb_dm_oe, swd_din;
  logic swd_clk_rise, jtag_active, key_window, on_chip_debug_circuits;
  logic prot_any, nvl_prog, write_once_security_latch, cpu_halt;
  logic trc_wrapped, swv_ready, blk_op_ok;
  dpal_pair_e swd_pair;
  // probe steering: unused pair idles at its parked level
  logic host_go, host_usb, host_busy, hclk, hdat;
  wire tck_i = host_usb ? 1'b0 : hclk;
  wire tms_i = host_usb ? 1'b1 : hdat;
  wire usb_dp_i = host_usb ? hclk : 1'b0;
  wire usb_dm_i = host_usb ? hdat : 1'b1;
  int miscompares, tests_run, n, acc;

  dpal_top i_dut (.*);
  dpal_host i_host (.go(host_go), .key(host_key), .sclk(hclk), .sdat(hdat),
    .busy(host_busy));

  // free running core clock
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // inputs move 1 ns after the edge
  task step;
    @(posedge clock);
    #1;
  endtask
  // one compare, counted
  task check(input string what, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // extra edges let strap and latch sampling settle
  task do_reset;
    arst_n = 1'b0;
    repeat (8) step;
    arst_n = 1'b1;
    repeat (3) step;
  endtask
  // send the key on one pair, then allow for synchroniser lag
  task acquire(input logic usb);
    host_usb = usb;
    host_key = `DPAL_ACQ_KEY;
    host_go = 1'b1;
    step;
    host_go = 1'b0;
    for (n = 0; n < 400 && host_busy; n++) step;
    repeat (8) step;
  endtask
  // cut a hang short
  initial begin
    #300000;
    miscompares++;
    wrap_up;
  end
  initial begin
    {arst_n, jtag_dis_cfg, jtag_tdo_core, jtag_tdo_en, swd_dout, swd_doe,
      swd_dis, swd_jtag_en, fw_jtag_dis, fw_doc_en, fw_doc_dis, full_erase,
      prot_set, blk_op_req, blk_sec_ok, wol_wr, wol_commit, dbg_halt_req,
      dbg_resume, dbg_step, cpu_retire, seq_en, trc_en, trc_all, trc_cont,
      trc_win_en, swv_en, swv_manch, swv_valid, host_go, host_usb} = '0;
    {wol_wdata, nonvolatile_latch_cell, bp_addr, bp_en, seq_first,
      seq_second, trc_trig, trc_win_lo, trc_win_hi, trc_rd_idx, cpu_state,
      cpu_mem, mbp_cfg, swv_word, host_key} = '0;
    do_reset;
    check("doc", on_chip_debug_circuits, 0);
    check("jtag", jtag_active, 1);
    check("pair", swd_pair, DPAL_PAIR_NONE);
    // usb pair leaves scan pins free
    acquire(1'b1);
    check("pair", swd_pair, DPAL_PAIR_USB);
    check("jtag", jtag_active, 1);
    fw_jtag_dis = 1'b1;
    step;
    fw_jtag_dis = 1'b0;
    step;
    check("jtag", jtag_active, 0);
    swd_jtag_en = 1'b1;
    step;
    swd_jtag_en = 1'b0;
    step;
    check("jtag", jtag_active, 1);
    swd_dis = 1'b1;
    step;
    swd_dis = 1'b0;
    step;
    check("pair", swd_pair, DPAL_PAIR_NONE);
    // a key after the window is ignored
    for (n = 0; n < 1200 && key_window; n++) step;
    acquire(1'b0);
    check("late", swd_pair, DPAL_PAIR_NONE);
    // scan pair taken, the other pair then refused
    do_reset;
    swd_doe = 1'b1;
    acquire(1'b0);
    check("pair", swd_pair, DPAL_PAIR_JTAG);
    check("jtag", jtag_active, 0);
    check("tms_oe", tms_oe, 1);
    check("dm_oe", usb_dm_oe, 0);
    acquire(1'b1);
    check("pair", swd_pair, DPAL_PAIR_JTAG);
    // viewer: fill with drain off, then watch the start bit
    swv_word = {5'h1f, 32'h0};
    swv_valid = 1'b1;
    acc = 0;
    repeat (40) begin
      acc += int'(swv_ready);
      step;
    end
    swv_valid = 1'b0;
    check("fill", acc, `DPAL_FIFO_DEPTH);
    swv_en = 1'b1;
    for (n = 0; n < 100 && tdo_o; n++) step;
    check("tdo_oe", tdo_oe, 1);
    for (n = 0; n < 40 && !tdo_o; n++) step;
    check("start", n, `DPAL_BAUD_DIV);
    // firmware enable, then every comparator in turn
    fw_doc_en = 1'b1;
    step;
    fw_doc_en = 1'b0;
    check("doc", on_chip_debug_circuits, 1);
    for (int k = 0; k < 9; k++) begin
      bp_en = (k < 8) ? 8'h01 << k : 8'h00;
      bp_addr = '0;
      bp_addr[16*(k%8) +: 16] = 16'h1000 | 16'(k);
      cpu_state.pc = 16'h1000 | 16'(k);
      mbp_cfg = {16'h0040, 8'h5a, 2'b11};
      cpu_mem = (k == 8) ? {16'h0040, 8'h5a, 2'b01} : '0;
      cpu_retire = (k < 8);
      step;
      {cpu_retire, cpu_mem} = '0;
      check("halt", cpu_halt, 1);
      dbg_resume = 1'b1;
      step;
      dbg_resume = 1'b0;
      step;
      check("run", cpu_halt, 0);
    end
    // ordered pair: second alone ignored, first then second halts
    {seq_en, seq_first, seq_second, bp_en} = {1'b1, 3'h1, 3'h2, 8'h06};
    bp_addr[16 +: 32] = {16'h2002, 16'h2001};
    for (int k = 0; k < 3; k++) begin
      cpu_state.pc = (k == 1) ? 16'h2001 : 16'h2002;
      cpu_retire = 1'b1;
      step;
      cpu_retire = 1'b0;
      check("seq", cpu_halt, k == 2);
    end
    // single step: release, then halt after one retire
    dbg_step = 1'b1;
    step;
    dbg_step = 1'b0;
    check("step", cpu_halt, 0);
    cpu_retire = 1'b1;
    step;
    cpu_retire = 1'b0;
    check("step", cpu_halt, 1);
    dbg_resume = 1'b1;
    {seq_en, bp_en} = '0;
    step;
    dbg_resume = 1'b0;
    check("run", cpu_halt, 0);
    // trace from the trigger, full buffer halts the cpu
    {trc_en, trc_all, trc_trig} = {2'b11, 16'h3000};
    for (int k = 0; k < 1002; k++) begin
      cpu_state = {16'h2ffe + 16'(k), 8'h11, 8'h22};
      cpu_retire = 1'b1;
      step;
      if (k == 6) check("count", trc_count, 5);
    end
    cpu_retire = 1'b0;
    check("full", cpu_halt, 1);
    check("wrap", trc_wrapped, 0);
    trc_rd_idx = '0;
    step;
    check("rec", trc_rd_data, {16'h3000, 8'h11, 8'h22});
    // refused enable only returns after a full erase
    fw_doc_dis = 1'b1;
    step;
    fw_doc_dis = 1'b0;
    fw_doc_en = 1'b1;
    step;
    fw_doc_en = 1'b0;
    check("doc", on_chip_debug_circuits, 0);
    full_erase = 1'b1;
    step;
    full_erase = 1'b0;
    fw_doc_en = 1'b1;
    step;
    fw_doc_en = 1'b0;
    check("doc", on_chip_debug_circuits, 1);
    // latch key write and commit, lock waits for reset
    wol_wdata = `DPAL_LOCK_KEY;
    wol_wr = 1'b1;
    step;
    wol_wr = 1'b0;
    check("stage", nvl_prog_data, `DPAL_LOCK_KEY);
    wol_commit = 1'b1;
    step;
    wol_commit = 1'b0;
    check("prog", nvl_prog, 1);
    step;
    check("prog", nvl_prog, 0);
    check("lock", write_once_security_latch, 0);
    prot_set = 1'b1;
    step;
    prot_set = 1'b0;
    check("prot", prot_any, 1);
    wol_wdata = '0;
    wol_wr = 1'b1;
    step;
    wol_wr = 1'b0;
    check("stage", nvl_prog_data, `DPAL_LOCK_KEY);
    full_erase = 1'b1;
    step;
    full_erase = 1'b0;
    check("prot", prot_any, 0);
    // 28 of 32 locks, 27 does not
    {blk_op_req, blk_sec_ok} = 2'b11;
    for (int f = 4; f < 6; f++) begin
      nonvolatile_latch_cell = `DPAL_LOCK_KEY ^ ((32'h1 << f) - 32'h1);
      do_reset;
      check("lock", write_once_security_latch, f == 4);
      check("jtag", jtag_active, f != 4);
      check("blk", blk_op_ok, f != 4);
      fw_doc_en = 1'b1;
      step;
      fw_doc_en = 1'b0;
      check("doc", on_chip_debug_circuits, f != 4);
    end
    // strap keeps the scan port off
    nonvolatile_latch_cell = '0;
    jtag_dis_cfg = 1'b1;
    do_reset;
    check("strap", jtag_active, 0);
    wrap_up;
  end
endmodule
